// ---- verilog/cfg_pkg.sv ----
// Constants and types of the serial output enable control block
package cfg_pkg;
  localparam logic [7:0] ADDR_SEL_HIGH = 8'hd2;
  localparam logic [7:0] ADDR_SEL_LOW = 8'hdc;
  localparam logic [1:0] DEVICE_SELECT = 2'h1;
  localparam int CMD_BYTE_BIT = 7;
  localparam int CMD_DEV_HI = 6;
  localparam int CMD_DEV_LO = 5;
  localparam logic [4:0] IDX_THRESH_FB = 5'h16;
  localparam logic [4:0] IDX_PAIR_EN = 5'h17;
  localparam logic [7:0] RST_THRESH_FB = 8'h0f;
  localparam logic [7:0] RST_PAIR_EN = 8'hff;
  localparam logic [7:0] BLOCK_BYTE_COUNT = 8'h18;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int PAIR_B1_BIT = 7;
  localparam int PAIR_B0_BIT = 6;
  localparam int PAIR_A2_BIT = 5;
  localparam int PAIR_A1_BIT = 3;
  localparam int PAIR_A0_BIT = 2;

  typedef struct packed {
    logic [1:0] threshold;
    logic feedback_a_disable;
    logic feedback_b_disable;
    logic [1:0] reserved_hi;
    logic pair_b2_enable;
    logic reserved_lo;
  } thresh_fb_type;

  typedef struct packed {
    logic [2:0] bank_a;
    logic [2:0] bank_b;
  } pair_en_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h3,
    ST_TX = 3'h2,
    ST_MACK = 3'h6
  } state_type;

  typedef enum logic [1:0] {
    ROLE_ADDR = 2'h0,
    ROLE_CMD = 2'h1,
    ROLE_COUNT = 2'h2,
    ROLE_DATA = 2'h3
  } role_type;
endpackage : cfg_pkg

// ---- verilog/output_enable_ctrl.sv ----
// Serial bus target and output enable logic of a six-pair clock buffer
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Byte and block reads and writes accepted
// - Address d2 when select high, dc low
// - Command bit 7: block 0, byte 1
// - Command bits 6:5 carry device select 01
// - Bits 4:0 index byte ops, zero block
// - Block bytes ascend by index, MSB first
// - Block read: restart, count then data bytes
// - Byte write: address, command, one data
// - Byte read: restart, address, one data
// - Bytes taken from byte 0, bit 7 first
// - Byte 22 bits 7:6 pick input threshold
// - Byte 22 bits 5,4 disable feedback outputs
// - Byte 22 bit 1 enables pair B2
// - Byte 23 bits enable B1,B0,A2,A1,A0
// - Registers load defaults, all outputs enabled
// - Serial access works during power down
// - Out of power down, true outputs follow input, complements invert
module output_enable_ctrl
  import cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_input,
  input wire logic power_down,
  input wire logic ref_in_a,
  input wire logic ref_in_b,
  output logic [2:0] bank_a_true_out,
  output logic [2:0] bank_a_comp_out,
  output logic [2:0] bank_b_true_out,
  output logic [2:0] bank_b_comp_out,
  output logic [2:0] bank_a_out_en,
  output logic [2:0] bank_b_out_en,
  output logic feedback_out_a,
  output logic feedback_out_b,
  output logic feedback_a_en,
  output logic feedback_b_en,
  output logic [1:0] threshold_select
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] asel_sync_reg;
  logic [1:0] pd_sync_reg;
  logic [1:0] ref_a_sync_reg;
  logic [1:0] ref_b_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      asel_sync_reg <= 2'h0;
      pd_sync_reg <= 2'h0;
      ref_a_sync_reg <= 2'h0;
      ref_b_sync_reg <= 2'h0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      asel_sync_reg <= {asel_sync_reg[0], address_select_input};
      pd_sync_reg <= {pd_sync_reg[0], power_down};
      ref_a_sync_reg <= {ref_a_sync_reg[0], ref_in_a};
      ref_b_sync_reg <= {ref_b_sync_reg[0], ref_in_b};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] own_addr;

  assign scl = scl_sync_reg[1];
  assign sda = sda_sync_reg[1];
  assign scl_rise = scl & ~scl_prev_reg;
  assign scl_fall = ~scl & scl_prev_reg;
  assign start_seen = scl & scl_prev_reg & ~sda & sda_prev_reg;
  assign stop_seen = scl & scl_prev_reg & sda & ~sda_prev_reg;
  assign own_addr = asel_sync_reg[1] ? ADDR_SEL_HIGH : ADDR_SEL_LOW;

  // ----------------------------------------------------------------
  // Configuration bytes
  // ----------------------------------------------------------------
  logic [7:0] thresh_fb_reg;
  logic [7:0] pair_en_reg;

  function automatic logic [7:0] read_cfg(input logic [4:0] idx,
                                          input logic [7:0] b22,
                                          input logic [7:0] b23);
    read_cfg = 8'h00;
    if (idx == IDX_THRESH_FB) begin
      read_cfg = b22;
    end else if (idx == IDX_PAIR_EN) begin
      read_cfg = b23;
    end
  endfunction : read_cfg

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  state_type state_reg;
  role_type role_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic rd_reg;
  logic byte_mode_reg;
  logic count_sent_reg;
  logic host_nack_reg;
  logic [4:0] index_reg;
  logic wr_en;
  logic got_byte_reg;
  logic [7:0] rd_data;

  // Byte to send next, zero for unused indices
  assign rd_data = read_cfg(index_reg, thresh_fb_reg, pair_en_reg);
  assign wr_en = scl_fall && state_reg == ST_RX && got_byte_reg
    && role_reg == ROLE_DATA && !rd_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      role_reg <= ROLE_ADDR;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      rd_reg <= 1'b0;
      byte_mode_reg <= 1'b0;
      count_sent_reg <= 1'b0;
      host_nack_reg <= 1'b0;
      index_reg <= 5'h00;
      got_byte_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_seen) begin
      state_reg <= ST_RX;
      role_reg <= ROLE_ADDR;
      bit_cnt_reg <= 3'h0;
      count_sent_reg <= 1'b0;
      got_byte_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_seen) begin
      state_reg <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            got_byte_reg <= bit_cnt_reg == LAST_BIT;
          end else if (scl_fall && got_byte_reg) begin
            got_byte_reg <= 1'b0;
            state_reg <= ST_ACK;
            sda_oe <= 1'b1;
            case (role_reg)
              ROLE_ADDR: begin
                rd_reg <= shift_reg[0];
                if (shift_reg[7:1] != own_addr[7:1]) begin
                  state_reg <= ST_IDLE;
                  sda_oe <= 1'b0;
                end
              end
              ROLE_CMD: begin
                byte_mode_reg <= shift_reg[CMD_BYTE_BIT];
                index_reg <= shift_reg[CMD_BYTE_BIT] ?
                  shift_reg[4:0] : 5'h00;
                role_reg <= shift_reg[CMD_BYTE_BIT] ?
                  ROLE_DATA : ROLE_COUNT;
                if (shift_reg[CMD_DEV_HI:CMD_DEV_LO] != DEVICE_SELECT) begin
                  state_reg <= ST_IDLE;
                  sda_oe <= 1'b0;
                end
              end
              ROLE_COUNT: role_reg <= ROLE_DATA;
              default: index_reg <= index_reg + 5'h01;
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 3'h0;
            if (rd_reg) begin
              state_reg <= ST_TX;
              if (!byte_mode_reg && !count_sent_reg) begin
                shift_reg <= BLOCK_BYTE_COUNT;
                sda_oe <= ~BLOCK_BYTE_COUNT[7];
              end else begin
                shift_reg <= rd_data;
                sda_oe <= ~rd_data[7];
              end
            end else begin
              state_reg <= ST_RX;
              sda_oe <= 1'b0;
              if (role_reg == ROLE_ADDR) begin
                role_reg <= ROLE_CMD;
              end
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == LAST_BIT) begin
              state_reg <= ST_MACK;
              sda_oe <= 1'b0;
              if (count_sent_reg || byte_mode_reg) begin
                index_reg <= index_reg + 5'h01;
              end
              count_sent_reg <= 1'b1;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            host_nack_reg <= sda;
          end else if (scl_fall) begin
            bit_cnt_reg <= 3'h0;
            if (host_nack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_TX;
              shift_reg <= rd_data;
              sda_oe <= ~rd_data[7];
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: the line is only ever pulled low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Register writes, independent of power down
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      thresh_fb_reg <= RST_THRESH_FB;
      pair_en_reg <= RST_PAIR_EN;
    end else if (wr_en) begin
      if (index_reg == IDX_THRESH_FB) begin
        thresh_fb_reg <= shift_reg;
      end else if (index_reg == IDX_PAIR_EN) begin
        pair_en_reg <= shift_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock outputs and enables
  // ----------------------------------------------------------------
  thresh_fb_type tf;
  pair_en_type pe;
  logic run;

  assign tf = thresh_fb_type'(thresh_fb_reg);
  assign pe.bank_a = {pair_en_reg[PAIR_A2_BIT], pair_en_reg[PAIR_A1_BIT],
                      pair_en_reg[PAIR_A0_BIT]};
  assign pe.bank_b = {tf.pair_b2_enable, pair_en_reg[PAIR_B1_BIT],
                      pair_en_reg[PAIR_B0_BIT]};
  assign run = ~pd_sync_reg[1];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bank_a_true_out <= 3'h0;
      bank_a_comp_out <= 3'h7;
      bank_b_true_out <= 3'h0;
      bank_b_comp_out <= 3'h7;
      feedback_out_a <= 1'b0;
      feedback_out_b <= 1'b0;
    end else begin
      bank_a_true_out <= {3{ref_a_sync_reg[1] & run}};
      bank_a_comp_out <= {3{~ref_a_sync_reg[1] & run}};
      bank_b_true_out <= {3{ref_b_sync_reg[1] & run}};
      bank_b_comp_out <= {3{~ref_b_sync_reg[1] & run}};
      feedback_out_a <= ref_a_sync_reg[1] & run;
      feedback_out_b <= ref_b_sync_reg[1] & run;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bank_a_out_en <= 3'h7;
      bank_b_out_en <= 3'h7;
      feedback_a_en <= 1'b1;
      feedback_b_en <= 1'b1;
      threshold_select <= 2'h0;
    end else begin
      bank_a_out_en <= pe.bank_a;
      bank_b_out_en <= pe.bank_b;
      feedback_a_en <= ~tf.feedback_a_disable;
      feedback_b_en <= ~tf.feedback_b_disable;
      threshold_select <= tf.threshold;
    end
  end

endmodule : output_enable_ctrl
`default_nettype wire

// ---- verification/smbus_host_model.sv ----
// Bus host model driving the serial clock and data lines
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model
  import cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sda_oe,
  output logic scl,
  output wire logic sda
);
  logic drv_low = 1'b0;
  initial scl = 1'b1;
  // Pull-up: line high unless a party pulls it low
  assign sda = !(drv_low | sda_oe);
  task q;
    repeat (5) @(negedge sys_clk);
  endtask : q
  task start;
    drv_low = 1'b0;
    q;
    scl = 1'b1;
    q;
    drv_low = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask : start
  task stop;
    drv_low = 1'b1;
    q;
    scl = 1'b1;
    q;
    drv_low = 1'b0;
    q;
  endtask : stop
  task bit_x(input logic b, output logic r);
    drv_low = !b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask : bit_x
  task wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : wr_byte
  task rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask : rd_byte
endmodule : smbus_host_model
`default_nettype wire

// ---- verification/output_enable_ctrl_assertions.sv ----
// Concurrent checks on the output enable control block ports
`timescale 1ns/100ps
`default_nettype none
module output_enable_ctrl_checker
  import cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic power_down,
  input wire logic ref_in_a,
  input wire logic ref_in_b,
  input wire logic [2:0] bank_a_true_out,
  input wire logic [2:0] bank_a_comp_out,
  input wire logic [2:0] bank_b_true_out,
  input wire logic [2:0] bank_b_comp_out,
  input wire logic [2:0] bank_a_out_en,
  input wire logic [2:0] bank_b_out_en,
  input wire logic feedback_out_a,
  input wire logic feedback_out_b,
  input wire logic feedback_a_en,
  input wire logic feedback_b_en,
  input wire logic [1:0] threshold_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_data_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled while clock high");
  a_data_quiet_high: assert property (scl_in[*3] |-> $stable(sda_oe))
    else $error("data changed while clock high");
  a_enable_scl_low: assert property (($changed(bank_a_out_en) ||
    $changed(bank_b_out_en)) |-> !scl_in) else $error("enable moved");
  a_reset_defaults: assert property ($rose(rstn) |->
    bank_a_out_en == 3'h7 && bank_b_out_en == 3'h7 && feedback_a_en &&
    feedback_b_en && threshold_select == 2'h0) else $error("bad default");
  a_true_follows_a: assert property ((!power_down && $stable(ref_in_a))[*6]
    |-> bank_a_true_out == {3{ref_in_a}}) else $error("bank a true");
  a_true_follows_b: assert property ((!power_down && $stable(ref_in_b))[*6]
    |-> bank_b_true_out == {3{ref_in_b}}) else $error("bank b true");
  a_comp_inverts_a: assert property ((!power_down)[*6] |->
    bank_a_comp_out == ~bank_a_true_out) else $error("bank a comp");
  a_comp_inverts_b: assert property ((!power_down)[*6] |->
    bank_b_comp_out == ~bank_b_true_out) else $error("bank b comp");
  a_feedback_follows_a: assert property (
    (!power_down && $stable(ref_in_a))[*6] |-> feedback_out_a == ref_in_a)
    else $error("feedback a");
  a_feedback_follows_b: assert property (
    (!power_down && $stable(ref_in_b))[*6] |-> feedback_out_b == ref_in_b)
    else $error("feedback b");
  a_power_down_low: assert property (power_down[*4] |->
    bank_a_true_out == 3'h0 && bank_a_comp_out == 3'h0 &&
    bank_b_true_out == 3'h0 && bank_b_comp_out == 3'h0 &&
    !feedback_out_a && !feedback_out_b) else $error("outputs not low");
endmodule : output_enable_ctrl_checker
bind output_enable_ctrl output_enable_ctrl_checker u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .power_down(power_down), .ref_in_a(ref_in_a),
  .ref_in_b(ref_in_b), .bank_a_true_out(bank_a_true_out),
  .bank_a_comp_out(bank_a_comp_out), .bank_b_true_out(bank_b_true_out),
  .bank_b_comp_out(bank_b_comp_out), .bank_a_out_en(bank_a_out_en),
  .bank_b_out_en(bank_b_out_en), .feedback_a_en(feedback_a_en),
  .feedback_out_a(feedback_out_a), .feedback_out_b(feedback_out_b),
  .feedback_b_en(feedback_b_en), .threshold_select(threshold_select));
`default_nettype wire

// ---- verification/tb_top.sv ----
// Testbench for the output enable control block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import cfg_pkg::*;
;
  logic sys_clk, rstn, address_select_input, power_down, ref_in_a, ref_in_b;
  logic scl, sda_out, sda_oe, ack, feedback_a_en, feedback_b_en;
  wire sda;
  logic [2:0] bank_a_out_en, bank_b_out_en;
  logic [1:0] threshold_select;
  logic [7:0] dev_adr, rd, v;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  output_enable_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_input(address_select_input), .power_down(power_down),
    .ref_in_a(ref_in_a), .ref_in_b(ref_in_b), .bank_a_true_out(),
    .bank_a_comp_out(), .bank_b_true_out(), .bank_b_comp_out(),
    .bank_a_out_en(bank_a_out_en), .bank_b_out_en(bank_b_out_en),
    .feedback_out_a(), .feedback_out_b(), .feedback_a_en(feedback_a_en),
    .feedback_b_en(feedback_b_en), .threshold_select(threshold_select));
  smbus_host_model h (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl),
    .sda(sda));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc % 7 == 0) ref_in_a <= !ref_in_a;
    if (cyc % 11 == 0) ref_in_b <= !ref_in_b;
  end
  task finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task send(input logic [7:0] d, input logic e);
    h.wr_byte(d, ack);
    chk({7'h0, ack}, {7'h0, e});
  endtask : send
  task byte_wr(input logic [7:0] cmd, input logic [7:0] d);
    h.start;
    send(dev_adr, 1'b1);
    send(cmd, 1'b1);
    send(d, 1'b1);
    h.stop;
  endtask : byte_wr
  task byte_rd(input logic [7:0] cmd, input logic [7:0] exp);
    h.start;
    send(dev_adr, 1'b1);
    send(cmd, 1'b1);
    h.start;
    send(dev_adr | 8'h01, 1'b1);
    h.rd_byte(1'b1, rd);
    chk(rd, exp);
    h.stop;
  endtask : byte_rd
  // Run is near 167 us; cut off well past it
  initial begin
    #500000;
    n_errors++;
    finish_test;
  end
  initial begin
    rstn = 1'b0;
    address_select_input = 1'b1;
    power_down = 1'b0;
    ref_in_a = 1'b0;
    ref_in_b = 1'b0;
    dev_adr = 8'hd2;
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({2'b0, bank_a_out_en, bank_b_out_en}, 8'h3f);
    chk({feedback_a_en, feedback_b_en, 4'h0, threshold_select}, 8'hc0);
    byte_rd(8'hb6, 8'h0f);
    byte_rd(8'hb7, 8'hff);
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], i[0], i[1], 2'b00, i[0], 1'b0};
      byte_wr(8'hb6, v);
      chk({threshold_select, feedback_a_en, feedback_b_en, bank_b_out_en[2],
        3'h0}, {i[1:0], !i[0], !i[1], i[0], 3'h0});
      byte_rd(8'hb6, v);
    end
    byte_wr(8'hb7, 8'h00);
    chk({2'b0, bank_a_out_en, bank_b_out_en}, 8'h04);
    byte_wr(8'ha5, 8'ha5);
    byte_rd(8'ha5, 8'h00);
    h.start;
    send(dev_adr, 1'b1);
    send(8'hd6, 1'b0);
    h.stop;
    h.start;
    send(dev_adr, 1'b1);
    send(8'h20, 1'b1);
    send(8'h18, 1'b1);
    for (int i = 0; i < 24; i++)
      send(i == 22 ? 8'h0f : i == 23 ? 8'ha4 : 8'h00, 1'b1);
    h.stop;
    chk({2'b0, bank_a_out_en, bank_b_out_en}, 8'h2e);
    h.start;
    send(dev_adr, 1'b1);
    send(8'h20, 1'b1);
    h.start;
    send(dev_adr | 8'h01, 1'b1);
    h.rd_byte(1'b0, rd);
    chk(rd, 8'h18);
    for (int i = 0; i < 24; i++) begin
      h.rd_byte(i == 23, rd);
      chk(rd, i == 22 ? 8'h0f : i == 23 ? 8'ha4 : 8'h00);
    end
    h.stop;
    power_down = 1'b1;
    address_select_input = 1'b0;
    dev_adr = 8'hdc;
    repeat (4) @(negedge sys_clk);
    h.start;
    send(8'hd2, 1'b0);
    h.stop;
    byte_wr(8'hb7, 8'hff);
    byte_rd(8'hb7, 8'hff);
    chk({2'b0, bank_a_out_en, bank_b_out_en}, 8'h3f);
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
